/* hdl/wide_passive_load.v */
// fast passive parallel configuration loader, device side
`timescale 1ns/1ps
`include "wide_passive_load_map.vh"
module wide_passive_load #(
	parameter [17:0] STATUS_MIN = `STATUS_MIN_CYC,
	parameter [17:0] STATUS_MAX = `STATUS_MAX_CYC,
	parameter [17:0] INIT_CYC = `INIT_MIN_CYC,
	parameter [31:0] IMAGE_WORDS = 32'h00000010
) (
	// clock and reset
	input wire ref_clk,
	input wire rstn,
	// configuration link
	input wire config_request_n,
	input wire status_in_n,
	input wire config_clock,
	input wire [31:0] config_data,
	input wire user_init_clock,
	// scheme select
	input wire [1:0] scheme_select,
	input wire decrypt_en,
	input wire decompress_en,
	input wire user_clock_init_en,
	input wire init_done_pin_en,
	// status pins
	output reg status_n_out,
	output reg status_n_oe,
	output reg load_done_out,
	output reg load_done_oe,
	output reg init_done_n,
	output reg init_done_oe,
	output reg user_mode,
	// loaded words
	output reg [31:0] word_q,
	output reg word_valid_q
);
	localparam [2:0] ST_POR = 3'h0, ST_RESET = 3'h1, ST_WAIT = 3'h2,
		ST_LOAD = 3'h3, ST_TAIL = 3'h4, ST_INIT = 3'h5, ST_USER = 3'h6;
	reg [2:0] st_q;
	reg [1:0] req_s, sts_s, dck_s, uck_s;
	reg dck_q, uck_q;
	reg [17:0] cnt_q;
	reg [3:0] phase_q;
	reg [31:0] words_q;
	reg [1:0] falls_q;
	reg [13:0] ucnt_q;
	reg [3:0] ratio;
	reg [31:0] dat_s0, dat_s1;
	reg [31:0] lane_d;
	wire req_n = req_s[1];
	wire dck_rise = dck_s[1] & ~dck_q;
	wire dck_fall = ~dck_s[1] & dck_q;
	wire uck_rise = uck_s[1] & ~uck_q;
	always @* begin
		ratio = 4'h1;
		if (scheme_select == `WIDTH_8) begin
			if (decompress_en)
				ratio = 4'h2;
		end else if (scheme_select == `WIDTH_16) begin
			if (decompress_en)
				ratio = 4'h4;
			else if (decrypt_en)
				ratio = 4'h2;
		end else begin
			if (decompress_en)
				ratio = 4'h8;
			else if (decrypt_en)
				ratio = 4'h4;
		end
	end
	// narrow schemes carry only their low lanes, the rest reads as zero
	always @* begin
		lane_d = dat_s1;
		if (scheme_select == `WIDTH_8)
			lane_d = {24'h000000, dat_s1[7:0]};
		else if (scheme_select == `WIDTH_16)
			lane_d = {16'h0000, dat_s1[15:0]};
	end
	// data rides the same two stages as the clock so they stay aligned
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			req_s <= 2'h0;
			dat_s0 <= 32'h00000000;
			dat_s1 <= 32'h00000000;
			sts_s <= 2'h0;
			dck_s <= 2'h0;
			uck_s <= 2'h0;
			dck_q <= 1'b0;
			uck_q <= 1'b0;
		end else begin
			req_s <= {req_s[0], config_request_n};
			sts_s <= {sts_s[0], status_in_n};
			dck_s <= {dck_s[0], config_clock};
			uck_s <= {uck_s[0], user_init_clock};
			dat_s0 <= config_data;
			dat_s1 <= dat_s0;
			dck_q <= dck_s[1];
			uck_q <= uck_s[1];
		end
	end
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= ST_POR;
			cnt_q <= 18'h00000;
			phase_q <= 4'h0;
			words_q <= 32'h00000000;
			falls_q <= 2'h0;
			ucnt_q <= 14'h0000;
			status_n_out <= 1'b0;
			status_n_oe <= 1'b1;
			load_done_out <= 1'b0;
			load_done_oe <= 1'b1;
			init_done_n <= 1'b0;
			init_done_oe <= 1'b0;
			user_mode <= 1'b0;
			word_q <= 32'h00000000;
			word_valid_q <= 1'b0;
		end else begin
			word_valid_q <= 1'b0;
			if (st_q != ST_POR && st_q != ST_RESET && !req_n) begin
				st_q <= ST_RESET;
				cnt_q <= 18'h00000;
				status_n_out <= 1'b0;
				status_n_oe <= 1'b1;
				load_done_out <= 1'b0;
				load_done_oe <= 1'b1;
				user_mode <= 1'b0;
				init_done_oe <= 1'b0;
			end else begin
				case (st_q)
				ST_POR, ST_RESET: begin
					status_n_out <= 1'b0;
					load_done_out <= 1'b0;
					if (cnt_q < STATUS_MAX)
						cnt_q <= cnt_q + 18'h00001;
					if (cnt_q >= STATUS_MIN && (req_n || cnt_q >= STATUS_MAX)
						&& req_n) begin
						status_n_out <= 1'b1;
						status_n_oe <= 1'b0;
						st_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					phase_q <= 4'h0;
					words_q <= 32'h00000000;
					if (sts_s[1] && dck_rise) begin
						st_q <= ST_LOAD;
						phase_q <= (ratio == 4'h1) ? 4'h0 : 4'h1;
						word_q <= lane_d;
						word_valid_q <= 1'b1;
						words_q <= 32'h00000001;
					end
				end
				ST_LOAD: begin
					if (!sts_s[1]) begin
						st_q <= ST_RESET;
						status_n_out <= 1'b0;
						status_n_oe <= 1'b1;
						cnt_q <= 18'h00000;
					end else if (words_q == IMAGE_WORDS) begin
						st_q <= ST_TAIL;
					end else if (dck_rise) begin
						if (phase_q == 4'h0) begin
							word_q <= lane_d;
							word_valid_q <= 1'b1;
							words_q <= words_q + 32'h00000001;
						end
						phase_q <= (phase_q + 4'h1 == ratio) ? 4'h0 :
							phase_q + 4'h1;
					end
				end
				ST_TAIL: begin
					if (dck_rise && phase_q != 4'h0)
						phase_q <= (phase_q + 4'h1 == ratio) ? 4'h0 :
							phase_q + 4'h1;
					else if (phase_q == 4'h0) begin
						load_done_out <= 1'b1;
						load_done_oe <= 1'b0;
						falls_q <= 2'h0;
						cnt_q <= 18'h00000;
						ucnt_q <= 14'h0000;
						st_q <= ST_INIT;
					end
				end
				ST_INIT: begin
					if (init_done_pin_en) begin
						init_done_oe <= 1'b1;
						init_done_n <= 1'b0;
					end
					if (dck_fall && falls_q != `END_FALLS)
						falls_q <= falls_q + 2'h1;
					if (falls_q == `END_FALLS) begin
						if (user_clock_init_en) begin
							if (uck_rise)
								ucnt_q <= ucnt_q + 14'h0001;
							if (ucnt_q == 14'd`USER_INIT_PERIODS)
								st_q <= ST_USER;
						end else begin
							cnt_q <= cnt_q + 18'h00001;
							if (cnt_q == INIT_CYC)
								st_q <= ST_USER;
						end
					end
				end
				default: begin
					user_mode <= 1'b1;
					init_done_n <= 1'b1;
				end
				endcase
			end
		end
	end
endmodule // wide_passive_load

/* hdl/wide_passive_load_map.vh */
// constants for the wide passive configuration loader
`ifndef WIDE_PASSIVE_LOAD_MAP_VH
`define WIDE_PASSIVE_LOAD_MAP_VH
`define CLK_PERIOD_NS 10
`define REQ_TO_LOW_NS 600
`define REQ_TO_LOW_CYC ((`REQ_TO_LOW_NS) / (`CLK_PERIOD_NS))
`define STATUS_MIN_US 268
`define STATUS_MIN_CYC ((`STATUS_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STATUS_MAX_US 1506
`define STATUS_MAX_CYC ((`STATUS_MAX_US * 1000) / (`CLK_PERIOD_NS))
`define INIT_MIN_US 175
`define INIT_MIN_CYC ((`INIT_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_MAX_US 437
`define INIT_MAX_CYC ((`INIT_MAX_US * 1000) / (`CLK_PERIOD_NS))
`define USER_CLK_DELAY_PERIODS 4
`define USER_INIT_PERIODS 8576
`define WIDTH_8 2'h0
`define WIDTH_16 2'h1
`define WIDTH_32 2'h2
`define END_FALLS 2
`endif

/* bench/wide_passive_load_chk.sv */
// assertions on the configuration loader pins
`timescale 1ns/1ps
module wide_passive_load_chk #(parameter [17:0] STATUS_MIN = 18'h1) (
	input wire ref_clk, rstn, config_request_n, status_n_oe,
	input wire load_done_oe, user_mode, word_valid_q,
	input wire init_done_n, init_done_oe,
	input wire [1:0] scheme_select,
	input wire [31:0] word_q
);
	reg [17:0] st_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence req_held; !config_request_n [*8]; endsequence
	// length of the current status low pulse
	always @(posedge ref_clk or negedge rstn)
		if (!rstn)
			st_q <= 18'h0;
		else
			st_q <= status_n_oe ? st_q + 18'h1 : 18'h0;
	AST_CD_LOW: assert property ($fell(config_request_n) |->
		##[0:60] load_done_oe) else $error("late load low");
	AST_ST_LOW: assert property ($fell(config_request_n) |->
		##[0:60] status_n_oe) else $error("late status low");
	AST_CD_HOLD: assert property (req_held |-> load_done_oe)
		else $error("load done released");
	AST_UM_LINES: assert property ($rose(user_mode) |->
		!load_done_oe && !status_n_oe) else $error("lines low");
	AST_ST_MIN: assert property ($fell(status_n_oe) |->
		$past(st_q) >= STATUS_MIN - 18'h1) else $error("short status");
	AST_IGNORE: assert property (user_mode |-> !word_valid_q)
		else $error("word in user mode");
	AST_NARROW: assert property (word_valid_q && scheme_select == 2'h0
		|-> word_q[31:8] == 24'h0) else $error("upper lanes used");
	AST_PULSE: assert property (word_valid_q |=> !word_valid_q)
		else $error("long word pulse");
	AST_INIT_LOW: assert property ($rose(init_done_oe) |->
		!init_done_n) else $error("init done high early");
endmodule // wide_passive_load_chk
bind wide_passive_load wide_passive_load_chk #(.STATUS_MIN(STATUS_MIN))
	wide_passive_load_chk_i (.*);

/* bench/config_host.sv */
// behavioural configuration host on the parallel link
`timescale 1ns/1ps
module config_host (
	input wire ref_clk, status_in_n,
	output logic config_request_n,
	output logic config_clock,
	output logic [31:0] config_data
);
	initial begin
		config_request_n = 1'b1;
		config_clock = 1'b0;
		config_data = 32'h00000000;
	end
	// clock stands low between frames
	task tick(input int n);
		repeat (n) begin
			#62.5 config_clock = 1'b1;
			#62.5 config_clock = 1'b0;
		end
	endtask
	task restart;
		@(posedge ref_clk) #1 config_request_n = 1'b0;
		repeat (201) @(posedge ref_clk);
		#1 config_request_n = 1'b1;
	endtask
	task send(input int n, input int r);
		wait (status_in_n);
		#2000;
		for (int i = 1; i <= n; i++) begin
			config_data = 32'h9E3779B9 * i;
			tick(r);
		end
		tick(r - 1);
		config_data = ~config_data;
	endtask
endmodule // config_host

/* bench/tb_wide_passive_load.sv */
// self-checking bench for the configuration loader
`timescale 1ns/1ps
module tb_wide_passive_load;
	logic ref_clk = 1'b0, rstn = 1'b0, decrypt_en = 1'b0, decompress_en = 1'b0;
	logic [1:0] scheme_select = 2'h0;
	logic [31:0] mask = 32'hFF;
	wire config_request_n, config_clock, status_n_out, status_n_oe, user_mode;
	wire load_done_out, load_done_oe, init_done_n, init_done_oe, word_valid_q;
	wire [31:0] config_data, word_q;
	logic user_init_clock = 1'b0, user_clock_init_en = 1'b0;
	logic init_done_pin_en = 1'b1;
	wire status_in_n = status_n_oe ? status_n_out : 1'b1;
	wire done_pin = load_done_oe ? load_done_out : 1'b1;
	int bad_count = 0, num_checks = 0, got = 0;
	// {width, decrypt, decompress, ratio}
	logic [7:0] rows [12] = '{8'h01, 8'h21, 8'h12, 8'h32, 8'h41, 8'h62,
		8'h54, 8'h74, 8'h81, 8'hA4, 8'h98, 8'hB8};
	wide_passive_load #(.STATUS_MIN(18'h32), .INIT_CYC(18'h64))
		wide_passive_load_i (.*);
	config_host config_host_i (.*);
	task check(input logic [31:0] act, exp);
		num_checks++;
		if (act !== exp) begin
			bad_count++;
			$display("[ERR] %0t %0h %0h", $time, act, exp);
		end
	endtask
	task summarize;
		if (bad_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial forever #5 ref_clk = ~ref_clk;
	initial forever #20 user_init_clock = ~user_init_clock;
	initial begin
		#800000 bad_count++;
		summarize;
	end
	always @(posedge ref_clk)
		if (word_valid_q) begin
			got++;
			check(word_q, 32'h9E3779B9 * got & mask);
		end
	initial begin
		repeat (6) @(posedge ref_clk);
		#1 rstn = 1'b1;
		for (int k = 0; k < 12; k++) begin
			@(posedge ref_clk) #1;
			{scheme_select, decrypt_en, decompress_en} = rows[k][7:4];
			mask = rows[k][7] ? 32'hFFFFFFFF : rows[k][6] ? 32'hFFFF : 32'hFF;
			init_done_pin_en = (k != 0);
			got = 0;
			config_host_i.restart;
			check(done_pin, 1'b0);
			check(status_in_n, 1'b0);
			config_host_i.send(16, rows[k][3:0]);
			repeat (100) @(posedge ref_clk);
			check(done_pin, 1'b1);
			check(init_done_oe, k != 0);
			check(got, 16);
			config_host_i.tick(2);
			repeat (260) @(posedge ref_clk);
			check(user_mode, 1'b1);
			check(init_done_n, 1'b1);
		end
		// initialisation from the user clock, narrow bus, no features
		{scheme_select, decrypt_en, decompress_en} = 4'h0;
		mask = 32'hFF;
		user_clock_init_en = 1'b1;
		got = 0;
		config_host_i.restart;
		config_host_i.send(16, 1);
		config_host_i.tick(2);
		repeat (8500) @(posedge user_init_clock);
		#1 check(user_mode, 1'b0);
		check(init_done_n, 1'b0);
		repeat (100) @(posedge user_init_clock);
		#1 check(user_mode, 1'b1);
		config_host_i.tick(4);
		check(got, 16);
		@(posedge ref_clk) #1 rstn = 1'b0;
		#1 check(status_in_n, 1'b0);
		check(done_pin, 1'b0);
		@(posedge ref_clk) #1 rstn = 1'b1;
		repeat (40) @(posedge ref_clk);
		check(status_in_n, 1'b0);
		check(user_mode, 1'b0);
		summarize;
	end
endmodule // tb_wide_passive_load
